// >>> verilog/start_gen_pkg.sv
// Package with register map, field positions and types of the I2C start generator.
package start_gen_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] CTRL2_OFFS  = 8'h00;
	localparam logic [7:0] STATUS_OFFS = 8'h04;
	localparam logic [7:0] RELOAD_OFFS = 8'h08;
	localparam logic [7:0] BUFFER_OFFS = 8'h0C;
	localparam logic [7:0] IRQ_OFFS    = 8'h10;
	localparam logic [7:0] MASK_OFFS   = 8'h14;

	// Field positions.
	localparam int START_REQ_BIT  = 0;
	localparam int START_SEEN_BIT = 3;
	localparam int CTRL2_LOW_W    = 5;
	localparam int RELOAD_W       = 7;
	localparam int IRQ_BCOL_BIT   = 0;
	localparam int IRQ_WRITE_COLLISION_FLAG_BIT   = 1;
	localparam int IRQ_DONE_BIT   = 2;
	localparam int IRQ_W          = 3;

	// Reset values.
	localparam logic [7:0]        CTRL2_RST  = 8'h00;
	localparam logic [7:0]        STATUS_RST = 8'h00;
	localparam logic [RELOAD_W-1:0] RELOAD_RST = 7'h00;
	localparam logic [7:0]        BUFFER_RST = 8'h00;
	localparam logic [IRQ_W-1:0]  IRQ_RST    = 3'h0;

	typedef enum logic [3:0]
	{
		ST_IDLE  = 4'b0001,
		ST_SETUP = 4'b0010,
		ST_HOLD  = 4'b0100,
		ST_DONE  = 4'b1000
	} start_state_e;

	typedef struct packed
	{
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_resp_s;

	typedef struct packed
	{
		start_state_e          state;
		logic [RELOAD_W-1:0]   count;
		logic [7:0]            ctrl2;
		logic [7:0]            status;
		logic [RELOAD_W-1:0]   reload;
		logic [7:0]            buffer;
		logic [IRQ_W-1:0]      irq;
		logic [IRQ_W-1:0]      mask;
		logic                  sda_low;
		logic [1:0]            scl_sync;
		logic [1:0]            sda_sync;
		apb_resp_s             resp;
	} start_gen_s;

endpackage : start_gen_pkg

// >>> verilog/i2c_start_gen.sv
// I2C master start condition generator with APB register access.
`timescale 1ns/1ps

// The block owns only the Start phase of a master transfer. It watches the
// resolved SCL and SDA levels through two flip-flops each. It pulls SDA low
// through an open-drain output to make the Start. It reports the result
// through sticky interrupt bits that software clears by writing ones.

// Function
// - Setting the start request bit begins a Start.
// - With SDA and SCL high, load counter from reload field and count.
// - At first timeout with both lines high, drive SDA low.
// - Pulling SDA low with SCL high sets start-seen status bit.
// - After SDA low, reload counter from the reload field again.
// - Second timeout clears start request, stops counter, SDA stays low.
// - Collision: both lines low at start, SCL low before SDA driven, or SDA low at first timeout.
// - Collision sets bus collision flag, aborts Start, returns to idle.
// - Buffer write during Start sets write collision, buffer unchanged.
// - Low five control bits ignore writes until Start completes.
module i2c_start_gen
(
	// Clock and reset
	input  wire logic        SYS_CLK_I,
	input  wire logic        RST_N_I,
	// APB slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// I2C pins, open drain
	input  wire logic        SCL_I,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_O,
	// Interrupt
	output logic             IRQ_O
);

	// All state lives in one packed struct. The combinational process below
	// builds the next copy, and one clocked process registers it. The APB
	// answer, the synchronisers and the Start sequencer therefore share one
	// reset and one clock edge, and no field can be left unassigned on a path.
	start_gen_pkg::start_gen_s st_reg;
	start_gen_pkg::start_gen_s st_next;

	logic scl_s;
	logic sda_s;
	logic wr_acc;
	logic rd_acc;
	logic timeout;

	assign scl_s   = st_reg.scl_sync[1];
	assign sda_s   = st_reg.sda_sync[1];
	assign wr_acc  = PSEL_I & PENABLE_I & PWRITE_I;
	assign rd_acc  = PSEL_I & PENABLE_I & ~PWRITE_I;
	// The rate counter counts down and holds at zero. Zero is the terminal
	// count, so one rate period lasts the reload value plus one clock.
	// The sequencer reloads the counter when it enters each timed phase, so
	// a stale zero from an earlier phase cannot end the next phase early.
	assign timeout = (st_reg.count == '0);

	always_comb
	begin
		logic                              busy;
		logic [start_gen_pkg::IRQ_W-1:0]   ev;
		logic                              mapped;
		busy   = (st_reg.state == start_gen_pkg::ST_SETUP) ||
		         (st_reg.state == start_gen_pkg::ST_HOLD);
		ev     = '0;
		mapped = 1'b1;
		st_next = st_reg;
		st_next.scl_sync = {st_reg.scl_sync[0], SCL_I};
		st_next.sda_sync = {st_reg.sda_sync[0], SDA_I};
		st_next.resp.pready  = 1'b0;
		st_next.resp.pslverr = 1'b0;
		st_next.resp.prdata  = '0;

		if (st_reg.count != '0)
		begin
			st_next.count = st_reg.count - 1'b1;
		end

		// Register access; the one-cycle answer follows the setup phase.
		// The setup cycle is decoded here, and the answer is registered so
		// that PREADY_O, PRDATA_O and PSLVERR_O all come from flip-flops.
		// Every access therefore has exactly one access cycle and no wait
		// state. An unmapped address answers with an error and zero data.
		if (PSEL_I & ~PENABLE_I)
		begin
			st_next.resp.pready = 1'b1;
			if (PADDR_I == start_gen_pkg::CTRL2_OFFS)
			begin
				st_next.resp.prdata = {24'h00_0000, st_reg.ctrl2};
			end
			else if (PADDR_I == start_gen_pkg::STATUS_OFFS)
			begin
				st_next.resp.prdata = {24'h00_0000, st_reg.status};
			end
			else if (PADDR_I == start_gen_pkg::RELOAD_OFFS)
			begin
				st_next.resp.prdata = {25'h000_0000, st_reg.reload};
			end
			else if (PADDR_I == start_gen_pkg::BUFFER_OFFS)
			begin
				st_next.resp.prdata = {24'h00_0000, st_reg.buffer};
			end
			else if (PADDR_I == start_gen_pkg::IRQ_OFFS)
			begin
				st_next.resp.prdata = {29'h0000_0000, st_reg.irq};
			end
			else if (PADDR_I == start_gen_pkg::MASK_OFFS)
			begin
				st_next.resp.prdata = {29'h0000_0000, st_reg.mask};
			end
			else
			begin
				mapped = 1'b0;
			end
			st_next.resp.pslverr = ~mapped;
		end

		// A write lands only at the edge that ends the access phase, where
		// the registered ready is high together with psel and penable.
		// Writes to unmapped addresses fall through every branch and are lost.
		if (wr_acc & st_reg.resp.pready)
		begin
			if (PADDR_I == start_gen_pkg::CTRL2_OFFS)
			begin
				// The upper control bits stay writable while a Start runs.
				// The low bits are frozen so that no second bus event can be
				// queued behind the Start in progress.
				st_next.ctrl2[7:start_gen_pkg::CTRL2_LOW_W] =
					PWDATA_I[7:start_gen_pkg::CTRL2_LOW_W];
				if (!busy)
				begin
					st_next.ctrl2[start_gen_pkg::CTRL2_LOW_W-1:0] =
						PWDATA_I[start_gen_pkg::CTRL2_LOW_W-1:0];
				end
			end
			else if (PADDR_I == start_gen_pkg::RELOAD_OFFS)
			begin
				st_next.reload = PWDATA_I[start_gen_pkg::RELOAD_W-1:0];
			end
			else if (PADDR_I == start_gen_pkg::BUFFER_OFFS)
			begin
				// A buffer write during a Start is refused and flagged; the
				// buffer keeps its old contents so no byte is half sent.
				if (busy)
				begin
					ev[start_gen_pkg::IRQ_WRITE_COLLISION_FLAG_BIT] = 1'b1;
				end
				else
				begin
					st_next.buffer = PWDATA_I[7:0];
				end
			end
			else if (PADDR_I == start_gen_pkg::STATUS_OFFS)
			begin
				st_next.status[start_gen_pkg::START_SEEN_BIT] = 1'b0;
			end
			else if (PADDR_I == start_gen_pkg::IRQ_OFFS)
			begin
				st_next.irq = st_reg.irq & ~PWDATA_I[start_gen_pkg::IRQ_W-1:0];
			end
			else if (PADDR_I == start_gen_pkg::MASK_OFFS)
			begin
				st_next.mask = PWDATA_I[start_gen_pkg::IRQ_W-1:0];
			end
		end

		// Start sequencer. IDLE waits for a request and free lines. SETUP
		// times the first rate period with SDA released and watches SCL for
		// a collision. HOLD times the second rate period with SDA pulled low.
		// DONE keeps SDA low until software asks for a new Start.
		// Every collision path clears the request bit and lands in IDLE, so
		// software sees the request bit fall on both success and abort.
		case (st_reg.state)
			start_gen_pkg::ST_IDLE:
			begin
				// A request seen with only one line low is left waiting,
				// since another master may still be finishing its own cycle.
				st_next.sda_low = 1'b0;
				if (st_reg.ctrl2[start_gen_pkg::START_REQ_BIT])
				begin
					if (scl_s & sda_s)
					begin
						st_next.count = st_reg.reload;
						st_next.state = start_gen_pkg::ST_SETUP;
					end
					else if (~scl_s & ~sda_s)
					begin
						ev[start_gen_pkg::IRQ_BCOL_BIT] = 1'b1;
						st_next.ctrl2[start_gen_pkg::START_REQ_BIT] = 1'b0;
					end
				end
			end
			start_gen_pkg::ST_SETUP:
			begin
				// SCL low before SDA is pulled means another master owns the
				// clock; SDA low at the timeout means it owns the data line.
				if (~scl_s)
				begin
					ev[start_gen_pkg::IRQ_BCOL_BIT] = 1'b1;
					st_next.ctrl2[start_gen_pkg::START_REQ_BIT] = 1'b0;
					st_next.state = start_gen_pkg::ST_IDLE;
				end
				else if (timeout & sda_s)
				begin
					st_next.sda_low = 1'b1;
					st_next.status[start_gen_pkg::START_SEEN_BIT] = 1'b1;
					st_next.count = st_reg.reload;
					st_next.state = start_gen_pkg::ST_HOLD;
				end
				else if (timeout)
				begin
					ev[start_gen_pkg::IRQ_BCOL_BIT] = 1'b1;
					st_next.ctrl2[start_gen_pkg::START_REQ_BIT] = 1'b0;
					st_next.state = start_gen_pkg::ST_IDLE;
				end
			end
			start_gen_pkg::ST_HOLD:
			begin
				// SDA is already low here, so no collision is checked; the
				// counter only times how long SDA is held before SCL may fall.
				if (timeout)
				begin
					st_next.ctrl2[start_gen_pkg::START_REQ_BIT] = 1'b0;
					ev[start_gen_pkg::IRQ_DONE_BIT] = 1'b1;
					st_next.state = start_gen_pkg::ST_DONE;
				end
			end
			start_gen_pkg::ST_DONE:
			begin
				// SDA stays low; a fresh request leaves the held bus.
				if (st_reg.ctrl2[start_gen_pkg::START_REQ_BIT])
				begin
					st_next.sda_low = 1'b0;
					st_next.state   = start_gen_pkg::ST_IDLE;
				end
			end
			default:
			begin
				st_next.state = start_gen_pkg::ST_IDLE;
			end
		endcase

		// Hardware set wins over a software clear in the same cycle.
		st_next.irq = st_next.irq | ev;
	end

	// Synchronous reset. The synchronisers reset to the released level of
	// the bus so that a Start requested just after reset is not taken for a
	// collision before real line levels have passed both flip-flops.
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			st_reg          <= '0;
			st_reg.state    <= start_gen_pkg::ST_IDLE;
			st_reg.ctrl2    <= start_gen_pkg::CTRL2_RST;
			st_reg.status   <= start_gen_pkg::STATUS_RST;
			st_reg.reload   <= start_gen_pkg::RELOAD_RST;
			st_reg.buffer   <= start_gen_pkg::BUFFER_RST;
			st_reg.irq      <= start_gen_pkg::IRQ_RST;
			st_reg.mask     <= start_gen_pkg::IRQ_RST;
			st_reg.scl_sync <= 2'b11;
			st_reg.sda_sync <= 2'b11;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// Outputs. SDA is open drain: the data output is always low and the
	// enable decides whether the line is pulled. The interrupt is a level
	// that stands while any unmasked sticky bit is set.
	assign PRDATA_O  = st_reg.resp.prdata;
	assign PREADY_O  = st_reg.resp.pready;
	assign PSLVERR_O = st_reg.resp.pslverr;
	assign SDA_O     = 1'b0;
	assign SDA_OE_O  = st_reg.sda_low;
	assign IRQ_O     = |(st_reg.irq & st_reg.mask);

endmodule : i2c_start_gen

// >>> testbench/i2c_peer.sv
// Other I2C devices on the shared bus and the wired bus levels.
`timescale 1ns/1ps
module i2c_peer
(
	// Bench control
	input  wire logic hold_i,
	input  wire logic run_i,
	// Bus
	input  wire logic oe_i,
	output logic      scl_o,
	output logic      sda_o
);
	logic scl_q;
	initial
	begin
		scl_q = 1'b1;
		#7;
		forever #160 scl_q = run_i ? !scl_q : 1'b1;
	end
	// Both lines have pull-ups, so a released line reads high.
	assign scl_o = scl_q && !hold_i;
	assign sda_o = !oe_i && !hold_i;
endmodule : i2c_peer

// >>> testbench/i2c_start_gen_asserts.sv
// Port checker of the I2C start generator.
`timescale 1ns/1ps
module i2c_start_gen_asserts
(
	// Watched ports
	input wire logic        SYS_CLK_I,
	input wire logic        RST_N_I,
	input wire logic        PSEL_I,
	input wire logic        PENABLE_I,
	input wire logic [31:0] PRDATA_O,
	input wire logic        PREADY_O,
	input wire logic        PSLVERR_O,
	input wire logic        SCL_I,
	input wire logic        SDA_I,
	input wire logic        SDA_O,
	input wire logic        SDA_OE_O,
	input wire logic        IRQ_O
);
	default clocking cb @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	rdy_pulse_a: assert property (PSEL_I && !PENABLE_I |=> PREADY_O ##1 !PREADY_O)
		else $error("Ready pulse wrong.");
	rdy_cause_a: assert property (PREADY_O |-> $past(PSEL_I && !PENABLE_I))
		else $error("Ready without setup.");
	err_zero_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0000_0000)
		else $error("Error answer wrong.");
	sda_const_a: assert property (!SDA_O)
		else $error("SDA driven high.");
	sda_fall_a: assert property (
		$rose(SDA_OE_O) |-> SCL_I) else $error("SDA fell with SCL low.");
	sda_cause_a: assert property (
		$rose(SDA_OE_O) |-> $past(SDA_I, 3)) else $error("SDA fell while low.");
	hold_low_a: assert property (
		$rose(SDA_OE_O) |=> SDA_OE_O [*4]) else $error("SDA hold too short.");
	reset_quiet_a: assert property (disable iff (1'b0)
		!RST_N_I |=> !SDA_OE_O && !IRQ_O && !PREADY_O) else $error("Reset not quiet.");
endmodule : i2c_start_gen_asserts

bind i2c_start_gen i2c_start_gen_asserts u_i2c_start_gen_asserts (.SYS_CLK_I(SYS_CLK_I),
	.RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PRDATA_O(PRDATA_O),
	.PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .SCL_I(SCL_I), .SDA_I(SDA_I),
	.SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .IRQ_O(IRQ_O));

// >>> testbench/i2c_start_gen_tb.sv
// Self-checking bench of the I2C start generator.
`timescale 1ns/1ps
module i2c_start_gen_tb;
	localparam CT = start_gen_pkg::CTRL2_OFFS;
	localparam ST = start_gen_pkg::STATUS_OFFS;
	localparam RL = start_gen_pkg::RELOAD_OFFS;
	localparam BF = start_gen_pkg::BUFFER_OFFS;
	localparam IQ = start_gen_pkg::IRQ_OFFS;
	localparam MK = start_gen_pkg::MASK_OFFS;
	logic        clk, rst_n, psel, penable, pwrite, hold, run;
	logic        pready, pslverr, scl, sda, sda_out, sda_oe, irq, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	int          n_fail, cmp_count, cyc, c;

	i2c_start_gen u_i2c_start_gen (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl),
		.SDA_I(sda), .SDA_O(sda_out), .SDA_OE_O(sda_oe), .IRQ_O(irq));
	i2c_peer u_i2c_peer (.hold_i(hold), .run_i(run), .oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = !clk;
	end

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_fail++;
			close_out();
		end
	end

	task automatic close_out();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk

	// Holds the request until ready is seen high at a rising edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask : rdc

	task automatic t_reset();
		rdc(CT, 32'h0000_0000);
		rdc(ST, 32'h0000_0000);
		rdc(IQ, 32'h0000_0000);
		apb(1'b0, 8'h20, 32'h0000_0000);
		chk(err, 32'h0000_0001);
		$display("reset test done");
	endtask : t_reset

	task automatic t_both_low();
		hold <= 1'b1;
		apb(1'b1, MK, 32'h0000_0001);
		apb(1'b1, CT, 32'h0000_0001);
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(irq, 32'h0000_0001);
		chk(sda_oe, 32'h0000_0000);
		rdc(CT, 32'h0000_0000);
		rdc(IQ, 32'h0000_0001);
		hold <= 1'b0;
		apb(1'b1, IQ, 32'h0000_0001);
		rdc(IQ, 32'h0000_0000);
		$display("both-low collision test done");
	endtask : t_both_low

	task automatic t_start();
		apb(1'b1, RL, 32'h0000_0028);
		rdc(RL, 32'h0000_0028);
		apb(1'b1, MK, 32'h0000_0004);
		apb(1'b1, CT, 32'h0000_0001);
		while (sda_oe !== 1'b1) @(posedge clk);
		fork
			begin
				c = 0;
				while (irq !== 1'b1)
				begin
					@(posedge clk);
					c++;
				end
			end
			begin
				apb(1'b1, BF, 32'h0000_005A);
				apb(1'b1, CT, 32'h0000_001E);
			end
		join
		chk(c, 41);
		chk(sda_oe, 32'h0000_0001);
		rdc(CT, 32'h0000_0000);
		rdc(ST, 32'h0000_0008);
		rdc(BF, 32'h0000_0000);
		rdc(IQ, 32'h0000_0006);
		apb(1'b1, MK, 32'h0000_0000);
		@(negedge clk);
		chk(irq, 32'h0000_0000);
		apb(1'b1, IQ, 32'h0000_0006);
		rdc(IQ, 32'h0000_0000);
		apb(1'b1, BF, 32'h0000_0033);
		rdc(BF, 32'h0000_0033);
		$display("start test done");
	endtask : t_start

	task automatic t_scl_coll();
		apb(1'b1, MK, 32'h0000_0001);
		apb(1'b1, CT, 32'h0000_0001);
		run <= 1'b1;
		while (irq !== 1'b1) @(posedge clk);
		run <= 1'b0;
		@(negedge clk);
		chk(sda_oe, 32'h0000_0000);
		rdc(CT, 32'h0000_0000);
		rdc(IQ, 32'h0000_0001);
		$display("clock collision test done");
	endtask : t_scl_coll

	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		hold = 1'b0;
		run = 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_both_low();
		t_start();
		t_scl_coll();
		close_out();
	end
endmodule : i2c_start_gen_tb
